// ### cspa_defs.svh
// Constants for the core status, program counter and addressing block
`ifndef CSPA_DEFS_SVH
`define CSPA_DEFS_SVH

// Timing: core clock and instruction cycle
`define CSPA_CLK_NS      50
`define CSPA_CYC_NS      200
`define CSPA_CYC_CLKS    ((`CSPA_CYC_NS) / (`CSPA_CLK_NS))

// Core register file locations (low five address bits)
`define CSPA_ADR_INDIRECT 5'h00
`define CSPA_ADR_PCL      5'h02
`define CSPA_ADR_STATUS   5'h03
`define CSPA_ADR_FSR      5'h04
`define CSPA_ADR_OSC      5'h05

// Status field positions
`define CSPA_ST_CARRY    0
`define CSPA_ST_HALF     1
`define CSPA_ST_ZERO     2
`define CSPA_ST_PD       3
`define CSPA_ST_TO       4
`define CSPA_ST_PAGE_LO  5
`define CSPA_ST_PAGE_HI  7

// Reset values
`define CSPA_STATUS_RST  8'h18
`define CSPA_TCFG_RST    8'hFF
`define CSPA_OSC_RST     8'hFE
`define CSPA_OSC_MASK    8'hFE
`define CSPA_PC_RST      11'h7FF
`define CSPA_BSR_RST     3'h0
`define CSPA_FSR_RST     8'h00
`define CSPA_ACC_RST     8'h00
`define CSPA_STK_RST     12'h000

// Widths and depths
`define CSPA_PC_W        11
`define CSPA_STK_W       12
`define CSPA_STK_DEPTH   4

`endif

// ### cspa_pkg.sv
// Types shared by the core status, program counter and addressing block
package cspa_pkg;

  // Control flow and special operations of the executing instruction
  typedef enum logic [3:0] {
    OP_NONE, OP_JUMP, OP_CALL, OP_RETURN, OP_RET_LIT, OP_RET_IRQ, OP_IRQ_ENTRY,
    OP_BANK_LOAD, OP_TIMER_LOAD, OP_WDT_CLEAR, OP_SLEEP
  } cspa_op_t;

  // Flag behaviour of the arithmetic part
  typedef enum logic [2:0] {
    ALU_NONE, ALU_LOGIC, ALU_ADD, ALU_SUB, ALU_ROT_R, ALU_ROT_L
  } cspa_alu_t;

  // One instruction as presented by the decoder
  typedef struct packed {
    cspa_op_t   op;
    cspa_alu_t  alu;
    logic [8:0] lit;
    logic [4:0] file_addr;
    logic [7:0] operand;
    logic [7:0] result;
    logic       wr_file;
    logic       wr_acc;
  } cspa_exec_t;

  // Timer configuration register layout, bit 7 first
  typedef struct packed {
    logic       portb_change_wake_n;
    logic       portb_pullup_n;
    logic       timer_source_select;
    logic       timer_edge_select;
    logic       prescaler_target;
    logic [2:0] prescale_rate;
  } cspa_tcfg_t;

endpackage

// ### cspa_ret_stack.sv
// Four-level return address stack
`timescale 1ns/1ps
`include "cspa_defs.svh"
module cspa_ret_stack (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   push_i,
  input  wire logic                   pop_i,
  input  wire logic [`CSPA_STK_W-1:0] push_data_i,
  output logic      [`CSPA_STK_W-1:0] top_o
);
  import cspa_pkg::*;

  logic [`CSPA_STK_W-1:0] lvl [`CSPA_STK_DEPTH];

  // Each level shifts down on push, up on pop; the deepest refills itself
  for (genvar k = 0; k < `CSPA_STK_DEPTH; k++) begin : g_lvl
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        lvl[k] <= `CSPA_STK_RST;
      end else if (push_i) begin
        lvl[k] <= (k == 0) ? push_data_i : lvl[(k == 0) ? 0 : k - 1];
      end else if (pop_i) begin
        lvl[k] <= (k == `CSPA_STK_DEPTH - 1) ? lvl[k] : lvl[(k == `CSPA_STK_DEPTH - 1) ? k : k + 1];
      end
    end
  end

  // Level 1 is read straight from its register
  assign top_o = lvl[0];

endmodule

// ### cspa_core.sv
// Core status, timer configuration, trim, program counter, stack and addressing
//
// Summary of operation
// - Flag-updating results override status flag writes.
// - Timeout and powerdown bits ignore software writes.
// - Timeout set on power-up, clear-watchdog, sleep.
// - Powerdown set on power-up/clear-watchdog, cleared by sleep.
// - Null flag follows zero result.
// - Half carry from bit 3 add, inverted borrow.
// - Timer configuration written only from accumulator.
// - Reset sets all timer configuration bits.
// - Bits 7 and 6 enable wake/pull-up, low.
// - Bit 5 selects source, bit 4 edge.
// - Bit 3 assigns prescaler; rate doubles per code.
// - Output pins never get wake or pull-up.
// - Trim value in bits 7-1, bit 0 zero.
// - Instruction pointer advances once per instruction cycle.
// - Jump loads nine bits plus two page bits.
// - Call or counter write loads eight, clears bit 8.
// - Reset points to last address, page zero.
// - Call or interrupt pushes pointer plus one.
// - Returns pop level 1, refill from level 4.
// - Direct address is bank select plus opcode.
// - Indirect port uses pointer; self access is null.
// - Two context copies of accumulator, status, pointers.
`timescale 1ns/1ps
`include "cspa_defs.svh"
module cspa_core #(
  parameter logic [`CSPA_PC_W-1:0] IRQ_VECTOR = 11'h004
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire cspa_pkg::cspa_exec_t   exec_i,
  input  wire logic                   isr_i,
  input  wire logic                   wdt_timeout_i,
  input  wire logic [7:0]             pin_direction_i,
  output logic                        cyc_en_o,
  output logic [`CSPA_PC_W-1:0]       instr_pointer_o,
  output logic [7:0]                  acc_o,
  output logic [7:0]                  status_o,
  output logic [7:0]                  eff_addr_o,
  output logic                        wr_ext_o,
  output logic [7:0]                  wr_data_o,
  output logic [7:0]                  rd_data_o,
  output logic                        rd_hit_o,
  output cspa_pkg::cspa_tcfg_t        timer_config_o,
  output logic [3:0]                  timer_ratio_log2_o,
  output logic [3:0]                  wdt_ratio_log2_o,
  output logic [6:0]                  osc_trim_o,
  output logic [7:0]                  pb_wake_en_o,
  output logic [7:0]                  pb_pullup_en_o
);
  import cspa_pkg::*;

  logic [1:0]             div_cnt;
  logic                   cyc_en;
  logic                   ctx;
  logic [7:0]             acc_q  [2];
  logic [7:0]             st_q   [2];
  logic [7:0]             fsr_q  [2];
  logic [2:0]             bsr_q  [2];
  logic [7:0]             osc_q;
  cspa_tcfg_t             tcfg_q;
  logic [`CSPA_PC_W-1:0]  pc_q;
  logic [`CSPA_PC_W-1:0]  pc_inc;
  logic [`CSPA_STK_W-1:0] stk_top;
  logic                   push;
  logic                   pop;
  logic                   is_ind;
  logic [7:0]             eff_addr;
  logic [4:0]             lo_addr;
  logic                   ind_null;
  logic                   hit_pcl;
  logic                   hit_st;
  logic                   hit_fsr;
  logic                   hit_osc;
  logic                   core_hit;
  logic                   wr_go;
  logic [7:0]             cur_st;
  logic [7:0]             alu_res;
  logic [2:0]             flag_upd;
  logic [2:0]             flag_val;
  logic [8:0]             sum9;
  logic [4:0]             sum5;

  // Instruction cycle enable from the core clock divider
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_cnt <= 2'h0;
    end else if (cyc_en) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign cyc_en   = (div_cnt == 2'(`CSPA_CYC_CLKS - 1));
  assign cyc_en_o = cyc_en;

  // Context copy in use follows the interrupt service level
  assign ctx    = isr_i;
  assign cur_st = st_q[ctx];

  // Direct and indirect address resolution
  assign is_ind   = (exec_i.file_addr == `CSPA_ADR_INDIRECT);
  assign eff_addr = is_ind ? fsr_q[ctx] : {bsr_q[ctx], exec_i.file_addr};
  assign lo_addr  = eff_addr[4:0];
  assign ind_null = is_ind && (lo_addr == `CSPA_ADR_INDIRECT);
  assign hit_pcl  = !ind_null && (lo_addr == `CSPA_ADR_PCL);
  assign hit_st   = !ind_null && (lo_addr == `CSPA_ADR_STATUS);
  assign hit_fsr  = !ind_null && (lo_addr == `CSPA_ADR_FSR);
  assign hit_osc  = !ind_null && (lo_addr == `CSPA_ADR_OSC) && !eff_addr[5];
  assign core_hit = ind_null | hit_pcl | hit_st | hit_fsr | hit_osc;
  assign wr_go    = cyc_en && exec_i.wr_file;

  // Arithmetic result and flags, ordered {null, half carry, carry}
  always_comb begin
    sum9     = 9'h000;
    sum5     = 5'h00;
    alu_res  = exec_i.result;
    flag_upd = 3'h0;
    flag_val = 3'h0;
    unique case (exec_i.alu)
      ALU_LOGIC: begin
        flag_upd = 3'h4;
        flag_val = {(alu_res == 8'h00), 2'h0};
      end
      ALU_ADD: begin
        sum9     = {1'b0, exec_i.operand} + {1'b0, acc_q[ctx]};
        sum5     = {1'b0, exec_i.operand[3:0]} + {1'b0, acc_q[ctx][3:0]};
        alu_res  = sum9[7:0];
        flag_upd = 3'h7;
        flag_val = {(sum9[7:0] == 8'h00), sum5[4], sum9[8]};
      end
      ALU_SUB: begin
        sum9     = {1'b0, exec_i.operand} - {1'b0, acc_q[ctx]};
        sum5     = {1'b0, exec_i.operand[3:0]} - {1'b0, acc_q[ctx][3:0]};
        alu_res  = sum9[7:0];
        flag_upd = 3'h7;
        flag_val = {(sum9[7:0] == 8'h00), !sum5[4], !sum9[8]};
      end
      ALU_ROT_R: begin
        alu_res  = {cur_st[`CSPA_ST_CARRY], exec_i.operand[7:1]};
        flag_upd = 3'h1;
        flag_val = {2'h0, exec_i.operand[0]};
      end
      ALU_ROT_L: begin
        alu_res  = {exec_i.operand[6:0], cur_st[`CSPA_ST_CARRY]};
        flag_upd = 3'h1;
        flag_val = {2'h0, exec_i.operand[7]};
      end
      ALU_NONE: begin
        flag_upd = 3'h0;
      end
      default: begin
        flag_upd = 3'h0;
      end
    endcase
  end

  // Status copies: flags, page bits, hardware-only reset-cause bits
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_b_i) begin
        st_q[c] <= `CSPA_STATUS_RST;
      end else begin
        if (cyc_en && (ctx == c[0])) begin
          if (wr_go && hit_st) begin
            st_q[c][`CSPA_ST_PAGE_HI:`CSPA_ST_PAGE_LO] <= alu_res[7:5];
          end
          for (int b = 0; b < 3; b++) begin
            if (flag_upd[b]) begin
              st_q[c][b] <= flag_val[b];
            end else if (wr_go && hit_st && (flag_upd == 3'h0)) begin
              // Any flag update locks all three flag bits against the write
              st_q[c][b] <= alu_res[b];
            end
          end
        end
        // Bits 4 and 3 take no software data at all
        if (cyc_en && (exec_i.op == OP_WDT_CLEAR || exec_i.op == OP_SLEEP)) begin
          st_q[c][`CSPA_ST_TO] <= 1'b1;
        end else if (wdt_timeout_i) begin
          st_q[c][`CSPA_ST_TO] <= 1'b0;
        end
        if (cyc_en && exec_i.op == OP_WDT_CLEAR) begin
          st_q[c][`CSPA_ST_PD] <= 1'b1;
        end else if (cyc_en && exec_i.op == OP_SLEEP) begin
          st_q[c][`CSPA_ST_PD] <= 1'b0;
        end
      end
    end
  end

  // Accumulator copies
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_b_i) begin
        acc_q[c] <= `CSPA_ACC_RST;
      end else if (cyc_en && (ctx == c[0])) begin
        if (exec_i.op == OP_RET_LIT) begin
          acc_q[c] <= exec_i.lit[7:0];
        end else if (exec_i.wr_acc) begin
          acc_q[c] <= alu_res;
        end
      end
    end
  end

  // Indirect pointer and bank select copies
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!rst_b_i) begin
        fsr_q[c] <= `CSPA_FSR_RST;
        bsr_q[c] <= `CSPA_BSR_RST;
      end else if (cyc_en && (ctx == c[0])) begin
        if (wr_go && hit_fsr) begin
          fsr_q[c] <= alu_res;
        end
        if (exec_i.op == OP_BANK_LOAD) begin
          bsr_q[c] <= exec_i.lit[2:0];
        end
      end
    end
  end

  // Oscillator trim, bit 0 held at zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      osc_q <= `CSPA_OSC_RST;
    end else if (wr_go && hit_osc) begin
      osc_q <= alu_res & `CSPA_OSC_MASK;
    end
  end
  assign osc_trim_o = osc_q[7:1];

  // Write-only timer configuration, loaded from the accumulator only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tcfg_q <= cspa_tcfg_t'(`CSPA_TCFG_RST);
    end else if (cyc_en && exec_i.op == OP_TIMER_LOAD) begin
      tcfg_q <= cspa_tcfg_t'(acc_q[ctx]);
    end
  end
  assign timer_config_o = tcfg_q;

  // Prescale ratios as powers of two for the two possible owners
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_ratio_log2_o <= 4'h0;
      wdt_ratio_log2_o   <= 4'h0;
    end else begin
      timer_ratio_log2_o <= tcfg_q.prescaler_target ? 4'h0 : {1'b0, tcfg_q.prescale_rate} + 4'h1;
      wdt_ratio_log2_o   <= tcfg_q.prescaler_target ? {1'b0, tcfg_q.prescale_rate} : 4'h0;
    end
  end

  // Per-pin wake and pull-up enables; an output pin gets neither
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        pb_wake_en_o[i]   <= 1'b0;
        pb_pullup_en_o[i] <= 1'b0;
      end else begin
        pb_wake_en_o[i]   <= !tcfg_q.portb_change_wake_n && pin_direction_i[i];
        pb_pullup_en_o[i] <= !tcfg_q.portb_pullup_n && pin_direction_i[i];
      end
    end
  end

  // Stack control
  assign pc_inc = pc_q + 11'h001;
  assign push   = cyc_en && (exec_i.op == OP_CALL || exec_i.op == OP_IRQ_ENTRY);
  assign pop    = cyc_en && (exec_i.op == OP_RETURN || exec_i.op == OP_RET_LIT ||
                             exec_i.op == OP_RET_IRQ);

  cspa_ret_stack u_stack (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i ({1'b0, pc_inc}),
    .top_o       (stk_top)
  );

  // Instruction pointer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pc_q <= `CSPA_PC_RST;
    end else if (cyc_en) begin
      unique case (exec_i.op)
        OP_JUMP: pc_q <= {cur_st[6:5], exec_i.lit[8:0]};
        OP_CALL: pc_q <= {cur_st[6:5], 1'b0, exec_i.lit[7:0]};
        OP_RETURN, OP_RET_LIT, OP_RET_IRQ: pc_q <= stk_top[`CSPA_PC_W-1:0];
        OP_IRQ_ENTRY: pc_q <= IRQ_VECTOR;
        OP_NONE, OP_BANK_LOAD, OP_TIMER_LOAD, OP_WDT_CLEAR, OP_SLEEP: begin
          if (wr_go && hit_pcl) begin
            pc_q <= {cur_st[6:5], 1'b0, alu_res};
          end else begin
            pc_q <= pc_inc;
          end
        end
        default: pc_q <= pc_inc;
      endcase
    end
  end
  assign instr_pointer_o = pc_q;

  // Read port for core registers, registered
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
      rd_hit_o  <= 1'b0;
    end else begin
      rd_hit_o <= core_hit;
      if (ind_null) begin
        rd_data_o <= 8'h00;
      end else if (hit_pcl) begin
        rd_data_o <= pc_q[7:0];
      end else if (hit_st) begin
        rd_data_o <= cur_st;
      end else if (hit_fsr) begin
        rd_data_o <= fsr_q[ctx];
      end else if (hit_osc) begin
        rd_data_o <= osc_q;
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // Writes to the rest of the register file; null indirect writes vanish
  assign eff_addr_o = eff_addr;
  assign wr_ext_o   = wr_go && !core_hit;
  assign wr_data_o  = alu_res;
  assign acc_o      = acc_q[ctx];
  assign status_o   = cur_st;

endmodule

// ### cspa_core_checker.sv
// Concurrent checks on the ports of the core block
`timescale 1ns/1ps
module cspa_core_checker (
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  input wire cspa_pkg::cspa_exec_t exec_i,
  input wire logic                 isr_i,
  input wire logic                 wdt_timeout_i,
  input wire logic [7:0]           pin_direction_i,
  input wire logic                 cyc_en_o,
  input wire logic [10:0]          instr_pointer_o,
  input wire logic [7:0]           acc_o,
  input wire logic [7:0]           status_o,
  input wire logic [7:0]           eff_addr_o,
  input wire logic                 wr_ext_o,
  input wire logic [7:0]           pb_pullup_en_o,
  input wire cspa_pkg::cspa_tcfg_t timer_config_o
);
  import cspa_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Executing edge of the current instruction
  logic go;
  assign go = cyc_en_o && rst_b_i;
  property p_cyc; cyc_en_o |=> !cyc_en_o [*3] ##1 cyc_en_o; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle enable period wrong");
  property p_inc;
    go && exec_i.op inside {OP_NONE, OP_BANK_LOAD, OP_TIMER_LOAD} && exec_i.file_addr > 5'h02
    |=> instr_pointer_o == $past(instr_pointer_o) + 11'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not advance");
  property p_jump;
    go && exec_i.op == OP_JUMP |=> instr_pointer_o == {$past(status_o[6:5]), $past(exec_i.lit)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_call;
    go && exec_i.op == OP_CALL
    |=> instr_pointer_o == {$past(status_o[6:5]), 1'b0, $past(exec_i.lit[7:0])};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_ro;
    go && exec_i.op == OP_NONE && exec_i.wr_file && exec_i.file_addr == 5'h03 && !wdt_timeout_i
    |=> ($stable(isr_i) -> status_o[4:3] == $past(status_o[4:3]));
  endproperty
  a_ro: assert property (p_ro) else $error("reset status bits written");
  property p_sleep; go && exec_i.op == OP_SLEEP |=> status_o[4:3] == 2'b10; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_clr; go && exec_i.op == OP_WDT_CLEAR |=> status_o[4:3] == 2'b11; endproperty
  a_clr: assert property (p_clr) else $error("clear flags wrong");
  property p_tout;
    wdt_timeout_i && !(go && exec_i.op inside {OP_SLEEP, OP_WDT_CLEAR}) |=> !status_o[4];
  endproperty
  a_tout: assert property (p_tout) else $error("timeout not cleared");
  property p_tload; go && exec_i.op == OP_TIMER_LOAD |=> timer_config_o == $past(acc_o); endproperty
  a_tload: assert property (p_tload) else $error("timer config load wrong");
  property p_thold; !(go && exec_i.op == OP_TIMER_LOAD) |=> $stable(timer_config_o); endproperty
  a_thold: assert property (p_thold) else $error("timer config changed");
  property p_mask; 1'b1 |=> (pb_pullup_en_o & ~$past(pin_direction_i)) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("pull-up on output pin");
  property p_rlit;
    go && exec_i.op == OP_RET_LIT |=> ($stable(isr_i) -> acc_o == $past(exec_i.lit[7:0]));
  endproperty
  a_rlit: assert property (p_rlit) else $error("literal not loaded");
  property p_null;
    go && exec_i.wr_file && exec_i.file_addr == 5'h00 && eff_addr_o[4:0] == 5'h00 |-> !wr_ext_o;
  endproperty
  a_null: assert property (p_null) else $error("null indirect write leaked");
  // Main scenarios reached
  c_call: cover property (go && exec_i.op == OP_CALL);
  c_rlit: cover property (go && exec_i.op == OP_RET_LIT);
  c_tload: cover property (go && exec_i.op == OP_TIMER_LOAD && acc_o[3]);
endmodule
bind cspa_core cspa_core_checker u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .exec_i(exec_i), .isr_i(isr_i),
  .wdt_timeout_i(wdt_timeout_i), .pin_direction_i(pin_direction_i), .cyc_en_o(cyc_en_o),
  .instr_pointer_o(instr_pointer_o), .acc_o(acc_o), .status_o(status_o),
  .eff_addr_o(eff_addr_o), .wr_ext_o(wr_ext_o), .pb_pullup_en_o(pb_pullup_en_o),
  .timer_config_o(timer_config_o)
);

// ### testbench.sv
// Directed instruction-level testbench for the core block
`timescale 1ns/1ps
module testbench;
  import cspa_pkg::*;
  localparam cspa_exec_t NOP = '0;
  logic clk_i = 1'b0, rst_b_i = 1'b0, isr_i = 1'b0, wdt_timeout_i = 1'b0;
  logic [7:0] pin_direction_i = 8'hF0;
  cspa_exec_t exec_i = NOP;
  logic cyc_en_o, wr_ext_o, rd_hit_o, wx, rh;
  logic [7:0] rd;
  logic [10:0] instr_pointer_o;
  logic [7:0] acc_o, status_o, eff_addr_o, wr_data_o, rd_data_o, pb_wake_en_o, pb_pullup_en_o, wd;
  logic [3:0] timer_ratio_log2_o, wdt_ratio_log2_o;
  logic [6:0] osc_trim_o;
  cspa_tcfg_t timer_config_o;
  int mismatches = 0, n_compared = 0;
  cspa_op_t pops [5] = '{OP_RETURN, OP_RET_IRQ, OP_RET_LIT, OP_RETURN, OP_RETURN};
  logic [10:0] pexp [5] = '{11'h041, 11'h031, 11'h021, 11'h011, 11'h011};
  cspa_core dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .exec_i(exec_i), .isr_i(isr_i),
    .wdt_timeout_i(wdt_timeout_i), .pin_direction_i(pin_direction_i), .cyc_en_o(cyc_en_o),
    .instr_pointer_o(instr_pointer_o), .acc_o(acc_o), .status_o(status_o),
    .eff_addr_o(eff_addr_o), .wr_ext_o(wr_ext_o), .wr_data_o(wr_data_o),
    .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .timer_config_o(timer_config_o),
    .timer_ratio_log2_o(timer_ratio_log2_o), .wdt_ratio_log2_o(wdt_ratio_log2_o),
    .osc_trim_o(osc_trim_o), .pb_wake_en_o(pb_wake_en_o), .pb_pullup_en_o(pb_pullup_en_o)
  );
  // 20 MHz core clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Present one instruction for its executing edge, then withdraw it
  task automatic do_op(input cspa_exec_t e);
    int n;
    n = 0;
    @(negedge clk_i);
    while (cyc_en_o !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    if (cyc_en_o !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    exec_i = e;
    #1;
    wx = wr_ext_o;
    wd = wr_data_o;
    @(negedge clk_i);
    rd = rd_data_o;
    rh = rd_hit_o;
    exec_i = NOP;
  endtask
  task automatic wr(input logic [4:0] f, input logic [7:0] r, input cspa_alu_t a);
    do_op('{OP_NONE, a, 9'h000, f, 8'h00, r, 1'b1, 1'b0});
  endtask
  task automatic ldw(input logic [7:0] r);
    do_op('{OP_NONE, ALU_NONE, 9'h000, 5'h10, 8'h00, r, 1'b0, 1'b1});
  endtask
  task automatic ctl(input cspa_op_t o, input logic [8:0] l);
    do_op('{o, ALU_NONE, l, 5'h10, 8'h00, 8'h00, 1'b0, 1'b0});
  endtask
  task automatic alu(input cspa_alu_t a, input logic [7:0] d, input logic w);
    do_op('{OP_NONE, a, 9'h000, 5'h10, d, 8'h00, 1'b0, w});
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk(instr_pointer_o, 11'h7FF);
    chk(status_o, 8'h18);
    chk(timer_config_o, 8'hFF);
    chk(osc_trim_o, 7'h7F);
    ctl(OP_NONE, 9'h000);
    chk(instr_pointer_o, 11'h000);
    ctl(OP_NONE, 9'h000);
    chk(instr_pointer_o, 11'h001);
    $display("test reset done");
    wr(5'h03, 8'hA7, ALU_NONE);
    chk(status_o, 8'hBF);
    wr(5'h03, 8'h00, ALU_LOGIC);
    chk(status_o, 8'h1F);
    wr(5'h10, 8'h5A, ALU_LOGIC);
    chk(status_o[2], 1'b0);
    ctl(OP_SLEEP, 9'h000);
    chk(status_o[4:3], 2'b10);
    @(negedge clk_i) wdt_timeout_i = 1'b1;
    @(negedge clk_i) wdt_timeout_i = 1'b0;
    chk(status_o[4:3], 2'b00);
    ctl(OP_WDT_CLEAR, 9'h000);
    chk(status_o[4:3], 2'b11);
    $display("test status done");
    ldw(8'h01);
    alu(ALU_ADD, 8'h0F, 1'b1);
    chk({acc_o, 5'h00, status_o[2:0]}, 16'h1002);
    alu(ALU_ADD, 8'hF0, 1'b1);
    chk({acc_o, 5'h00, status_o[2:0]}, 16'h0005);
    alu(ALU_SUB, 8'h05, 1'b0);
    chk(status_o[2:0], 3'b011);
    ldw(8'h01);
    alu(ALU_SUB, 8'h10, 1'b0);
    chk(status_o[2:0], 3'b001);
    alu(ALU_ROT_R, 8'h01, 1'b0);
    chk(status_o[0], 1'b1);
    alu(ALU_ROT_L, 8'h00, 1'b0);
    chk(status_o[0], 1'b0);
    $display("test arithmetic done");
    wr(5'h05, 8'h81, ALU_NONE);
    chk(osc_trim_o, 7'h40);
    ldw(8'hA5);
    ctl(OP_TIMER_LOAD, 9'h000);
    chk(timer_config_o, 8'hA5);
    @(negedge clk_i);
    chk({timer_ratio_log2_o, wdt_ratio_log2_o}, 8'h60);
    chk({pb_wake_en_o, pb_pullup_en_o}, 16'h00F0);
    ldw(8'h0D);
    ctl(OP_TIMER_LOAD, 9'h000);
    @(negedge clk_i);
    chk({timer_ratio_log2_o, wdt_ratio_log2_o}, 8'h05);
    chk({pb_wake_en_o, pb_pullup_en_o}, 16'hF0F0);
    $display("test timer done");
    wr(5'h03, 8'h40, ALU_NONE);
    ctl(OP_JUMP, 9'h123);
    chk(instr_pointer_o, 11'h523);
    ctl(OP_CALL, 9'h1AB);
    chk(instr_pointer_o, 11'h4AB);
    wr(5'h02, 8'h77, ALU_NONE);
    chk(instr_pointer_o, 11'h477);
    ctl(OP_RETURN, 9'h000);
    chk(instr_pointer_o, 11'h524);
    wr(5'h03, 8'h00, ALU_NONE);
    for (int i = 1; i <= 5; i++) ctl(OP_CALL, 9'(i * 16));
    for (int i = 0; i < 5; i++) begin
      ctl(pops[i], 9'h055);
      chk(instr_pointer_o, pexp[i]);
    end
    chk(acc_o, 8'h55);
    ctl(OP_IRQ_ENTRY, 9'h000);
    chk(instr_pointer_o, 11'h004);
    ctl(OP_RET_IRQ, 9'h000);
    chk(instr_pointer_o, 11'h012);
    $display("test stack done");
    @(negedge clk_i) isr_i = 1'b1;
    ldw(8'h99);
    chk(acc_o, 8'h99);
    isr_i = 1'b0;
    @(negedge clk_i);
    chk(acc_o, 8'h55);
    isr_i = 1'b1;
    @(negedge clk_i);
    chk(acc_o, 8'h99);
    isr_i = 1'b0;
    $display("test context done");
    wr(5'h04, 8'h10, ALU_NONE);
    wr(5'h00, 8'h3C, ALU_NONE);
    chk({6'h00, wx, rh, wd}, 16'h023C);
    wr(5'h04, 8'h00, ALU_NONE);
    chk({7'h00, rh, rd}, 16'h0110);
    wr(5'h00, 8'h3C, ALU_NONE);
    chk({6'h00, wx, rh, rd}, 16'h0100);
    ctl(OP_BANK_LOAD, 9'h003);
    @(negedge clk_i) exec_i = '{OP_NONE, ALU_NONE, 9'h000, 5'h0A, 8'h00, 8'h00, 1'b0, 1'b0};
    #1;
    chk(eff_addr_o, 8'h6A);
    @(negedge clk_i) exec_i = NOP;
    $display("test addressing done");
    tally_and_finish();
  end
endmodule
